// ---- fabric_consts.vh ----
`ifndef FABRIC_CONSTS_VH
`define FABRIC_CONSTS_VH

// ----------------------------------------------------------------------
// Target codes
// ----------------------------------------------------------------------
`define T_XRAM0       3'h0
`define T_XRAM1       3'h1
`define T_IRAM        3'h2
`define T_FLASH       3'h3
`define T_SFR         3'h4
`define T_XREG        3'h5
`define T_NONE        3'h6
`define NUM_TARGETS   6
`define NUM_MASTERS   3

// ----------------------------------------------------------------------
// Address spaces presented by a master
// ----------------------------------------------------------------------
`define SP_CODE       2'h0
`define SP_XDATA      2'h1
`define SP_DIRECT     2'h2
`define SP_INDIRECT   2'h3

// ----------------------------------------------------------------------
// External data space map
// ----------------------------------------------------------------------
`define XRAM0_BASE    16'h0000
`define XRAM1_BASE    16'h1000
`define XRAM_END      16'h2000
`define XREG_BASE     16'h7000
`define SFR_XBASE     16'h7F80
`define FLASH_XBASE   16'h8000
`define IDATA_UPPER   8'h80

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define XRAM_BYTES    4096
`define IRAM_BYTES    256
`define CACHE_WORDS   4

`endif

// ---- fabric_far_side.sv ----
`timescale 1ns/10ps
`default_nettype none

module fabric_far_side #(
  parameter int LAT = 3
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Flash array
  input  wire logic        i_flash_req,
  input  wire logic [14:0] i_flash_waddr,
  output logic             o_flash_ack,
  output logic      [15:0] o_flash_rdata,
  // Register ports
  input  wire logic        i_spec_en,
  input  wire logic [7:0]  i_spec_addr,
  output logic      [7:0]  o_spec_rdata,
  input  wire logic        i_xreg_en,
  input  wire logic [11:0] i_xreg_addr,
  output logic      [7:0]  o_xreg_rdata
);
  // ------------------
  // Slow flash array
  // ------------------
  logic [3:0]  cnt;
  logic [15:0] last;

  // Outside an acknowledge the data lines show the inverse of the last word.
  assign o_flash_ack   = i_flash_req && cnt == 4'(LAT);
  assign o_flash_rdata = o_flash_ack ?
      {i_flash_waddr[7:0] ^ 8'h5A, i_flash_waddr[14:7]} : ~last;
  assign o_spec_rdata  = i_spec_en ? i_spec_addr ^ 8'h5A : ~i_spec_addr;
  assign o_xreg_rdata  = i_xreg_en ? i_xreg_addr[7:0] ^ 8'h3C
                                   : ~i_xreg_addr[7:0];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt  <= 4'h0;
      last <= 16'h0000;
    end else begin
      cnt <= (i_flash_req && !o_flash_ack) ? cnt + 4'h1 : 4'h0;
      if (o_flash_ack) begin
        last <= o_flash_rdata;
      end
    end
  end
endmodule

`default_nettype wire

// ---- memory_fabric.v ----
// Notes on behaviour
// RQ1 - Three masters: core, DMA, AES engine.
// RQ2 - Two 4 kByte external RAMs, separate targets.
// RQ3 - 256 byte internal RAM, always retained.
// RQ4 - 64 kByte flash in code space.
// RQ5 - Special registers reached by direct addressing.
// RQ6 - Extra control registers in external space.
// RQ7 - Upper flash half readable via external window.
// RQ8 - Special registers also mapped in external space.
// RQ9 - Flash via four-word cache and prefetcher.
// RQ10 - Masters on different targets complete together.
// RQ11 - One arbiter per target picks one master.
// RQ12 - No requesting master is ever starved.
// RQ13 - Each external RAM retained or off separately.
// RQ14 - AES engine accesses memory sixteen bits wide.
// RQ15 - Software should align AES buffers evenly.
// RQ16 - Works at any clock up to 20 MHz.
// RQ17 - Upper internal half: direct to registers, indirect RAM.
// RQ18 - Round-robin grant, losers stall until granted.
// RQ19 - Flash window is read-only, writes ignored.
`timescale 1ns/10ps
`default_nettype none
`include "fabric_consts.vh"

module memory_fabric (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_rst,
  // Processor core master
  input  wire        i_cpu_req,
  input  wire [1:0]  i_cpu_space,
  input  wire [15:0] i_cpu_addr,
  input  wire        i_cpu_we,
  input  wire [7:0]  i_cpu_wdata,
  output wire        o_cpu_gnt,
  output reg  [7:0]  o_cpu_rdata,
  // DMA master
  input  wire        i_dma_req,
  input  wire [1:0]  i_dma_space,
  input  wire [15:0] i_dma_addr,
  input  wire        i_dma_we,
  input  wire [7:0]  i_dma_wdata,
  output wire        o_dma_gnt,
  output reg  [7:0]  o_dma_rdata,
  // AES master, sixteen bits per access
  input  wire        i_aes_req,
  input  wire [1:0]  i_aes_space,
  input  wire [15:0] i_aes_addr,
  input  wire        i_aes_we,
  input  wire [15:0] i_aes_wdata,
  output wire        o_aes_gnt,
  output reg  [15:0] o_aes_rdata,
  // Sleep control of the external RAMs
  input  wire        i_sleep,
  input  wire        i_xram0_retain,
  input  wire        i_xram1_retain,
  output wire        o_xram0_pwr,
  output wire        o_xram1_pwr,
  // Flash array read port
  output wire        o_flash_req,
  output wire [14:0] o_flash_waddr,
  input  wire        i_flash_ack,
  input  wire [15:0] i_flash_rdata,
  // Special function register port
  output wire        o_special_function_regs_en,
  output wire        o_special_function_regs_we,
  output wire [7:0]  o_special_function_regs_addr,
  output wire [7:0]  o_special_function_regs_wdata,
  input  wire [7:0]  i_special_function_regs_rdata,
  // Extra control register port
  output wire        o_xreg_en,
  output wire        o_xreg_we,
  output wire [11:0] o_xreg_addr,
  output wire [7:0]  o_xreg_wdata,
  input  wire [7:0]  i_xreg_rdata
);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function [2:0] decode;
    input [1:0]  space;
    input [15:0] a;
    begin
      case (space)
        `SP_CODE:     decode = `T_FLASH; // RQ4
        `SP_DIRECT:   decode = (a[7:0] >= `IDATA_UPPER) ?
                               `T_SFR : `T_IRAM; // RQ5 RQ17
        `SP_INDIRECT: decode = `T_IRAM; // RQ3 RQ17
        default: begin
          if (a < `XRAM1_BASE)
            decode = `T_XRAM0; // RQ2
          else if (a < `XRAM_END)
            decode = `T_XRAM1; // RQ2
          else if (a >= `FLASH_XBASE)
            decode = `T_FLASH; // RQ7
          else if (a >= `SFR_XBASE)
            decode = `T_SFR; // RQ8
          else if (a >= `XREG_BASE)
            decode = `T_XREG; // RQ6
          else
            decode = `T_NONE;
        end
      endcase
    end
  endfunction

  function [1:0] oh2idx;
    input [2:0] oh;
    begin
      oh2idx = oh[2] ? 2'h2 : (oh[1] ? 2'h1 : 2'h0);
    end
  endfunction

  // --------------------------------------------------------------------
  // Master side
  // --------------------------------------------------------------------
  reg         aes_phase;
  reg  [7:0]  aes_lo;
  wire [15:0] aes_eaddr = i_aes_addr + {15'h0000, aes_phase};
  wire [2:0]  aes_tgt   = decode(i_aes_space, aes_eaddr);
  // An even access to RAM or flash moves both bytes at once; anything
  // else is split into two byte phases, which costs one cycle more.
  wire        aes_one   = ~i_aes_addr[0] & ~aes_phase &
                          (aes_tgt <= `T_FLASH); // RQ14 RQ15

  wire [2:0]  req    = {i_aes_req, i_dma_req, i_cpu_req}; // RQ1
  wire [47:0] m_addr = {aes_eaddr, i_dma_addr, i_cpu_addr};
  wire [8:0]  m_tgt  = {aes_tgt, decode(i_dma_space, i_dma_addr),
                        decode(i_cpu_space, i_cpu_addr)};
  wire [2:0]  m_we   = {i_aes_we, i_dma_we, i_cpu_we};
  wire [7:0]  aes_wb = aes_phase ? i_aes_wdata[15:8] : i_aes_wdata[7:0];
  wire [23:0] m_wlo  = {aes_wb, i_dma_wdata, i_cpu_wdata};
  wire [2:0]  m_wide = {aes_one, 2'b00};

  // --------------------------------------------------------------------
  // Per-target arbitration
  // --------------------------------------------------------------------
  wire [17:0] treq;
  wire [17:0] arb_gnt;
  wire [5:0]  tready;
  wire [5:0]  tdone;
  wire [2:0]  done;

  genvar t;
  genvar m;
  generate
    for (t = 0; t < `NUM_TARGETS; t = t + 1) begin : g_tgt
      for (m = 0; m < `NUM_MASTERS; m = m + 1) begin : g_req
        assign treq[t*3+m] = req[m] & (m_tgt[m*3+:3] == t);
      end
      assign tdone[t] = |(arb_gnt[t*3+:3]) & tready[t];
      rr_arbiter #(
        .N  (3),
        .IW (2)
      ) u_arb (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_req     (treq[t*3+:3]),
        .i_advance (tdone[t]),
        .o_gnt     (arb_gnt[t*3+:3])
      ); // RQ11 RQ12
    end
    // A master completes when its own target grants it and is ready;
    // unmapped addresses complete at once and read zero.
    for (m = 0; m < `NUM_MASTERS; m = m + 1) begin : g_done
      assign done[m] = req[m] &
        ((m_tgt[m*3+:3] == `T_NONE) ||
         (arb_gnt[m_tgt[m*3+:3]*3+m] & tready[m_tgt[m*3+:3]])); // RQ10 RQ18
    end
  endgenerate

  assign o_cpu_gnt = done[0];
  assign o_dma_gnt = done[1];
  assign o_aes_gnt = done[2] & (aes_one | aes_phase);

  // Winning master's request, one set per target.
  wire [11:0] widx;
  wire [95:0] t_addr;
  wire [5:0]  t_we;
  wire [47:0] t_wlo;
  wire [5:0]  t_wide;
  generate
    for (t = 0; t < `NUM_TARGETS; t = t + 1) begin : g_sel
      assign widx[t*2+:2]    = oh2idx(arb_gnt[t*3+:3]);
      assign t_addr[t*16+:16] = m_addr[widx[t*2+:2]*16+:16];
      assign t_we[t]          = m_we[widx[t*2+:2]];
      assign t_wlo[t*8+:8]    = m_wlo[widx[t*2+:2]*8+:8];
      assign t_wide[t]        = m_wide[widx[t*2+:2]];
    end
  endgenerate

  // --------------------------------------------------------------------
  // RAM targets
  // --------------------------------------------------------------------
  reg  [7:0] xram0 [0:`XRAM_BYTES-1];
  reg  [7:0] xram1 [0:`XRAM_BYTES-1];
  reg  [7:0] iram  [0:`IRAM_BYTES-1];
  wire [11:0] a0 = t_addr[0*16+:12];
  wire [11:0] a1 = t_addr[1*16+:12];
  wire [7:0]  a2 = t_addr[2*16+:8];

  // Powered-off blocks lose their contents, so they read zero and
  // ignore writes until power returns.
  assign o_xram0_pwr = ~(i_sleep & ~i_xram0_retain); // RQ13
  assign o_xram1_pwr = ~(i_sleep & ~i_xram1_retain); // RQ13

  // The arrays have no reset so nothing disturbs retained contents.
  always @(posedge i_mclk) begin
    if (tdone[0] & t_we[0] & o_xram0_pwr) begin
      xram0[a0] <= t_wlo[0*8+:8];
      if (t_wide[0])
        xram0[{a0[11:1], 1'b1}] <= i_aes_wdata[15:8];
    end
    if (tdone[1] & t_we[1] & o_xram1_pwr) begin
      xram1[a1] <= t_wlo[1*8+:8];
      if (t_wide[1])
        xram1[{a1[11:1], 1'b1}] <= i_aes_wdata[15:8];
    end
    if (tdone[2] & t_we[2]) begin
      iram[a2] <= t_wlo[2*8+:8]; // RQ3
      if (t_wide[2])
        iram[{a2[7:1], 1'b1}] <= i_aes_wdata[15:8];
    end
  end

  assign tready[0] = 1'b1;
  assign tready[1] = 1'b1;
  assign tready[2] = 1'b1;
  assign tready[4] = 1'b1;
  assign tready[5] = 1'b1;

  // --------------------------------------------------------------------
  // Register targets
  // --------------------------------------------------------------------
  assign o_special_function_regs_en    = tdone[4]; // RQ5 RQ8
  assign o_special_function_regs_we    = t_we[4];
  assign o_special_function_regs_addr  = t_addr[4*16+:8];
  assign o_special_function_regs_wdata = t_wlo[4*8+:8];
  assign o_xreg_en    = tdone[5]; // RQ6
  assign o_xreg_we    = t_we[5];
  assign o_xreg_addr  = t_addr[5*16+:12];
  assign o_xreg_wdata = t_wlo[5*8+:8];

  // --------------------------------------------------------------------
  // Flash cache and prefetcher
  // --------------------------------------------------------------------
  localparam C_IDLE  = 2'h0;
  localparam C_FETCH = 2'h1;
  localparam C_PREF  = 2'h2;

  reg  [1:0]  c_state;
  reg  [59:0] c_tag;
  reg  [63:0] c_data;
  reg  [3:0]  c_valid;
  reg  [1:0]  victim;
  reg  [14:0] f_addr;
  wire [14:0] fw = t_addr[3*16+1+:15];

  function [4:0] lookup;
    input [14:0] w;
    integer e;
    begin
      lookup = 5'h00;
      for (e = 0; e < `CACHE_WORDS; e = e + 1) begin
        if (c_valid[e] && c_tag[e*15+:15] == w)
          lookup = {1'b1, 2'b00, e[1:0]};
      end
    end
  endfunction

  wire [4:0]  hit_fw  = lookup(fw);
  wire [4:0]  hit_nx  = lookup(f_addr + 15'h0001);
  wire [15:0] c_word  = c_data[hit_fw[1:0]*16+:16];
  // A hit is served in the same cycle; a miss stalls the winner while
  // the word is fetched. Writes are ignored but still complete.
  assign tready[3] = hit_fw[4] | t_we[3]; // RQ9 RQ19
  assign o_flash_req   = (c_state == C_FETCH) | (c_state == C_PREF);
  assign o_flash_waddr = f_addr;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      c_state <= C_IDLE;
      c_tag   <= 60'h000000000000000;
      c_data  <= 64'h0000000000000000;
      c_valid <= 4'h0;
      victim  <= 2'h0;
      f_addr  <= 15'h0000;
    end else begin
      case (c_state)
        C_IDLE: begin
          if (|treq[3*3+:3] && !tready[3]) begin
            f_addr  <= fw;
            c_state <= C_FETCH; // RQ9
          end
        end
        C_FETCH, C_PREF: begin
          if (i_flash_ack) begin
            c_tag[victim*15+:15]  <= f_addr;
            c_data[victim*16+:16] <= i_flash_rdata;
            c_valid[victim]       <= 1'b1;
            victim                <= victim + 2'h1;
            if (c_state == C_FETCH && !hit_nx[4]) begin
              f_addr  <= f_addr + 15'h0001;
              c_state <= C_PREF; // RQ9
            end else begin
              c_state <= C_IDLE;
            end
          end
        end
        default: c_state <= C_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read data return
  // --------------------------------------------------------------------
  wire [95:0] t_rd;
  assign t_rd[0*16+:16] = o_xram0_pwr ?
                          {xram0[{a0[11:1], 1'b1}], xram0[a0]} : 16'h0000;
  assign t_rd[1*16+:16] = o_xram1_pwr ?
                          {xram1[{a1[11:1], 1'b1}], xram1[a1]} : 16'h0000;
  assign t_rd[2*16+:16] = {iram[{a2[7:1], 1'b1}], iram[a2]};
  assign t_rd[3*16+:16] = t_addr[3*16] ? {8'h00, c_word[15:8]} : c_word;
  assign t_rd[4*16+:16] = {8'h00, i_special_function_regs_rdata};
  assign t_rd[5*16+:16] = {8'h00, i_xreg_rdata};

  wire [47:0] m_rd;
  generate
    for (m = 0; m < `NUM_MASTERS; m = m + 1) begin : g_rd
      assign m_rd[m*16+:16] = (m_tgt[m*3+:3] == `T_NONE) ? 16'h0000 :
                              t_rd[m_tgt[m*3+:3]*16+:16];
    end
  endgenerate

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cpu_rdata <= 8'h00;
      o_dma_rdata <= 8'h00;
      o_aes_rdata <= 16'h0000;
      aes_phase   <= 1'b0;
      aes_lo      <= 8'h00;
    end else begin
      if (done[0])
        o_cpu_rdata <= m_rd[0*16+:8];
      if (done[1])
        o_dma_rdata <= m_rd[1*16+:8];
      if (done[2]) begin
        if (aes_one) begin
          o_aes_rdata <= m_rd[2*16+:16]; // RQ14
        end else if (!aes_phase) begin
          aes_lo    <= m_rd[2*16+:8];
          aes_phase <= 1'b1;
        end else begin
          o_aes_rdata <= {m_rd[2*16+:8], aes_lo}; // RQ14
          aes_phase   <= 1'b0;
        end
      end
    end
  end

  // Fully synchronous and static: the same logic holds from a stopped
  // clock up to the 20 MHz system rate. // RQ16

endmodule
`default_nettype wire

// ---- memory_fabric_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fabric_consts.vh"

module memory_fabric_checker (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // Masters
  input wire logic        i_cpu_req,
  input wire logic [1:0]  i_cpu_space,
  input wire logic [15:0] i_cpu_addr,
  input wire logic        i_cpu_we,
  input wire logic [7:0]  i_cpu_wdata,
  input wire logic        o_cpu_gnt,
  input wire logic        i_dma_req,
  input wire logic [1:0]  i_dma_space,
  input wire logic [15:0] i_dma_addr,
  input wire logic        o_dma_gnt,
  input wire logic        i_aes_req,
  // Targets
  input wire logic        i_sleep,
  input wire logic        i_xram0_retain,
  input wire logic        i_xram1_retain,
  input wire logic        o_xram0_pwr,
  input wire logic        o_xram1_pwr,
  input wire logic        o_flash_req,
  input wire logic [14:0] o_flash_waddr,
  input wire logic        i_flash_ack,
  input wire logic        o_special_function_regs_en,
  input wire logic        o_special_function_regs_we,
  input wire logic [7:0]  o_special_function_regs_addr,
  input wire logic [7:0]  o_special_function_regs_wdata,
  input wire logic        o_xreg_en,
  input wire logic        o_xreg_we,
  input wire logic [11:0] o_xreg_addr,
  input wire logic [7:0]  o_xreg_wdata
);
  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  wire logic cpu_x  = i_cpu_req && i_cpu_space == `SP_XDATA;
  wire logic dma_x  = i_dma_req && i_dma_space == `SP_XDATA;
  wire logic cpu_x0 = cpu_x && i_cpu_addr[15:12] == 4'h0;
  wire logic dma_x0 = dma_x && i_dma_addr[15:12] == 4'h0;
  wire logic dma_x1 = dma_x && i_dma_addr[15:12] == 4'h1;
  wire logic spec   = o_special_function_regs_en;

  a_xram0_power: assert property (
    o_xram0_pwr == !(i_sleep && !i_xram0_retain))
    else $error("xram0 power wrong");
  a_xram1_power: assert property (
    o_xram1_pwr == !(i_sleep && !i_xram1_retain))
    else $error("xram1 power wrong");
  a_disjoint_parallel: assert property (
    cpu_x0 && dma_x1 && !i_aes_req |-> o_cpu_gnt && o_dma_gnt)
    else $error("parallel access stalled");
  a_single_winner: assert property (
    cpu_x0 && dma_x0 |-> !(o_cpu_gnt && o_dma_gnt))
    else $error("two masters granted");
  a_loser_next: assert property (
    cpu_x0 && dma_x0 && o_cpu_gnt && !i_aes_req |=> i_aes_req || o_dma_gnt)
    else $error("loser not granted next");
  a_dma_served: assert property (
    $rose(i_dma_req) |-> ##[0:60] o_dma_gnt)
    else $error("dma starved");
  a_direct_regs: assert property (
    i_cpu_req && i_cpu_space == `SP_DIRECT && i_cpu_addr[7] && o_cpu_gnt
    |-> spec && o_special_function_regs_addr == i_cpu_addr[7:0]
        && o_special_function_regs_we == i_cpu_we
        && (!i_cpu_we || o_special_function_regs_wdata == i_cpu_wdata))
    else $error("direct access misrouted");
  a_indirect_ram: assert property (
    i_cpu_req && i_cpu_space == `SP_INDIRECT && o_cpu_gnt && !i_dma_req
    && !i_aes_req |-> !spec)
    else $error("indirect access hit registers");
  a_xreg_route: assert property (
    cpu_x && i_cpu_addr inside {[16'h7000:16'h7F7F]} && o_cpu_gnt
    |-> o_xreg_en && o_xreg_addr == i_cpu_addr[11:0]
        && o_xreg_we == i_cpu_we
        && (!i_cpu_we || o_xreg_wdata == i_cpu_wdata))
    else $error("xreg access misrouted");
  a_window_regs: assert property (
    cpu_x && i_cpu_addr[15:7] == 9'h0FF && o_cpu_gnt
    |-> spec && o_special_function_regs_addr == i_cpu_addr[7:0])
    else $error("register window misrouted");
  a_fetch_holds: assert property (
    o_flash_req && !i_flash_ack |=> o_flash_req && $stable(o_flash_waddr))
    else $error("flash request dropped");
endmodule

bind memory_fabric memory_fabric_checker u_memory_fabric_checker (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_cpu_req(i_cpu_req),
  .i_cpu_space(i_cpu_space), .i_cpu_addr(i_cpu_addr), .i_cpu_we(i_cpu_we),
  .i_cpu_wdata(i_cpu_wdata),
  .o_cpu_gnt(o_cpu_gnt), .i_dma_req(i_dma_req), .i_dma_space(i_dma_space),
  .i_dma_addr(i_dma_addr), .o_dma_gnt(o_dma_gnt), .i_aes_req(i_aes_req),
  .i_sleep(i_sleep), .i_xram0_retain(i_xram0_retain),
  .i_xram1_retain(i_xram1_retain), .o_xram0_pwr(o_xram0_pwr),
  .o_xram1_pwr(o_xram1_pwr), .o_flash_req(o_flash_req),
  .o_flash_waddr(o_flash_waddr), .i_flash_ack(i_flash_ack),
  .o_special_function_regs_en(o_special_function_regs_en),
  .o_special_function_regs_we(o_special_function_regs_we),
  .o_special_function_regs_addr(o_special_function_regs_addr),
  .o_special_function_regs_wdata(o_special_function_regs_wdata),
  .o_xreg_en(o_xreg_en), .o_xreg_we(o_xreg_we), .o_xreg_addr(o_xreg_addr),
  .o_xreg_wdata(o_xreg_wdata));

`default_nettype wire

// ---- rr_arbiter.v ----
`timescale 1ns/10ps
`default_nettype none

module rr_arbiter #(
  parameter N  = 3,
  parameter IW = 2
) (
  // Clock and reset
  input  wire         i_mclk,
  input  wire         i_rst,
  // Requests and grant
  input  wire [N-1:0] i_req,
  input  wire         i_advance,
  output reg  [N-1:0] o_gnt
);

  localparam integer LAST0 = N - 1;

  reg [IW-1:0] last;
  reg          found;
  integer      k;
  integer      j;
  integer      p;

  // Search starts just past the last winner, so every requester is
  // reached within N completed accesses.
  always @* begin
    o_gnt = {N{1'b0}};
    found = 1'b0;
    for (k = 1; k <= N; k = k + 1) begin
      j = (last + k) % N;
      if (!found && i_req[j]) begin // RQ11 RQ18
        o_gnt[j] = 1'b1;
        found    = 1'b1;
      end
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      last <= LAST0[IW-1:0];
    end else if (i_advance) begin
      for (p = 0; p < N; p = p + 1) begin
        if (o_gnt[p]) begin
          last <= p[IW-1:0]; // RQ12
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fabric_consts.vh"

module tb_top;
  // ------------------
  // Stimulus and checks
  // ------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  req = 3'h0;
  logic [2:0]  we = 3'h0;
  logic [1:0]  sp [3] = '{default: 2'h0};
  logic [15:0] ad [3] = '{default: 16'h0000};
  logic [15:0] wd [3] = '{default: 16'h0000};
  logic        slp = 1'b0;
  logic [1:0]  ret = 2'h0;
  logic [15:0] v;
  int          t;
  int          fail_count = 0;
  int          n_checks = 0;
  wire  [2:0]  g;
  wire  [1:0]  pw;
  wire  [7:0]  rc, rm, sa, srd, xrd;
  wire  [15:0] ra, frd;
  wire  [14:0] fa;
  wire  [11:0] xa;
  wire         fq, fk, se, xe;

  initial begin
    forever #2 clk = ~clk;
  end

  memory_fabric u_memory_fabric (
    .i_mclk(clk), .i_rst(rst), .i_cpu_req(req[0]), .i_cpu_space(sp[0]),
    .i_cpu_addr(ad[0]), .i_cpu_we(we[0]), .i_cpu_wdata(wd[0][7:0]),
    .o_cpu_gnt(g[0]), .o_cpu_rdata(rc), .i_dma_req(req[1]),
    .i_dma_space(sp[1]), .i_dma_addr(ad[1]), .i_dma_we(we[1]),
    .i_dma_wdata(wd[1][7:0]), .o_dma_gnt(g[1]), .o_dma_rdata(rm),
    .i_aes_req(req[2]), .i_aes_space(sp[2]), .i_aes_addr(ad[2]),
    .i_aes_we(we[2]), .i_aes_wdata(wd[2]), .o_aes_gnt(g[2]),
    .o_aes_rdata(ra), .i_sleep(slp), .i_xram0_retain(ret[0]),
    .i_xram1_retain(ret[1]), .o_xram0_pwr(pw[0]), .o_xram1_pwr(pw[1]),
    .o_flash_req(fq), .o_flash_waddr(fa), .i_flash_ack(fk),
    .i_flash_rdata(frd), .o_special_function_regs_en(se),
    .o_special_function_regs_we(), .o_special_function_regs_addr(sa),
    .o_special_function_regs_wdata(), .i_special_function_regs_rdata(srd),
    .o_xreg_en(xe), .o_xreg_we(), .o_xreg_addr(xa), .o_xreg_wdata(),
    .i_xreg_rdata(xrd));

  fabric_far_side #(.LAT(3)) u_fabric_far_side (
    .i_mclk(clk), .i_rst(rst), .i_flash_req(fq), .i_flash_waddr(fa),
    .o_flash_ack(fk), .o_flash_rdata(frd), .i_spec_en(se),
    .i_spec_addr(sa), .o_spec_rdata(srd), .i_xreg_en(xe),
    .i_xreg_addr(xa), .o_xreg_rdata(xrd));

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_t(input string n, input int e, input int s);
    n_checks++;
    if (s != e) begin
      fail_count++;
      $display("[FAIL] %s cycles expected %0d seen %0d", n, e, s);
    end
  endtask

  // Holding h keeps the request up so the next call runs back to back.
  task automatic acc(input int m, input logic [1:0] s,
                     input logic [15:0] a, input logic w,
                     input logic [15:0] d, input bit h,
                     output logic [15:0] r, output int n);
    n = 0;
    r = 16'h0000;
    req[m] <= 1'b1;
    sp[m] <= s;
    ad[m] <= a;
    we[m] <= w;
    wd[m] <= d;
    forever begin
      @(negedge clk);
      n++;
      if (g[m] === 1'b1) break;
    end
    @(posedge clk);
    if (!h) begin
      req[m] <= 1'b0;
      @(negedge clk);
      r = m == 0 ? {8'h00, rc} : m == 1 ? {8'h00, rm} : ra;
      @(posedge clk);
    end
  endtask

  task automatic rdt(input string n, input int m, input logic [1:0] s,
                     input logic [15:0] a, input logic [15:0] e,
                     input int tc);
    acc(m, s, a, 1'b0, 16'h0000, 1'b0, v, t);
    chk(n, e, v);
    if (tc > 0) chk_t(n, tc, t);
  endtask

  task automatic wr(input int m, input logic [1:0] s,
                    input logic [15:0] a, input logic [15:0] d);
    acc(m, s, a, 1'b1, d, 1'b0, v, t);
  endtask

  task automatic t_rr();
    int a1, a2, b;
    logic [15:0] x, y;
    fork
      begin
        acc(0, `SP_XDATA, 16'h0020, 1'b1, 16'h00A1, 1'b1, x, a1);
        acc(0, `SP_XDATA, 16'h0021, 1'b1, 16'h00A2, 1'b0, x, a2);
      end
      acc(1, `SP_XDATA, 16'h0030, 1'b1, 16'h00B1, 1'b0, y, b);
    join
    chk_t("rr_cpu_first", 1, a1);
    chk_t("rr_dma_next", 2, b);
    chk_t("rr_cpu_again", 2, a2);
    rdt("rr_word", 2, `SP_XDATA, 16'h0020, 16'hA2A1, 1);
    rdt("rr_dma", 1, `SP_XDATA, 16'h0030, 16'h00B1, 1);
  endtask

  task automatic t_par();
    int a, b;
    logic [15:0] x, y;
    fork
      acc(0, `SP_XDATA, 16'h0FFF, 1'b1, 16'h0011, 1'b0, x, a);
      acc(1, `SP_XDATA, 16'h1000, 1'b1, 16'h0022, 1'b0, y, b);
    join
    chk_t("par_cpu", 1, a);
    chk_t("par_dma", 1, b);
    rdt("xram0_top", 1, `SP_XDATA, 16'h0FFF, 16'h0011, 1);
    rdt("xram1_base", 0, `SP_XDATA, 16'h1000, 16'h0022, 1);
  endtask

  task automatic t_map();
    wr(0, `SP_INDIRECT, 16'h0085, 16'h0077);
    rdt("iram_ind", 0, `SP_INDIRECT, 16'h0085, 16'h0077, 1);
    rdt("regs_dir", 0, `SP_DIRECT, 16'h0085, 16'h00DF, 1);
    wr(0, `SP_DIRECT, 16'h0090, 16'h0012);
    wr(1, `SP_DIRECT, 16'h0010, 16'h0066);
    rdt("iram_low", 1, `SP_INDIRECT, 16'h0010, 16'h0066, 1);
    rdt("regs_xwin", 0, `SP_XDATA, 16'h7F85, 16'h00DF, 1);
    rdt("xreg", 0, `SP_XDATA, 16'h7005, 16'h0039, 1);
    wr(0, `SP_XDATA, 16'h7006, 16'h0044);
    rdt("unmapped", 0, `SP_XDATA, 16'h3000, 16'h0000, 1);
  endtask

  task automatic t_flash();
    rdt("code_miss", 0, `SP_CODE, 16'h0100, 16'h0001, 6);
    wait (!fq);
    @(posedge clk);
    rdt("code_hit", 0, `SP_CODE, 16'h0101, 16'h00DA, 1);
    rdt("prefetch", 2, `SP_CODE, 16'h0102, 16'hDB01, 1);
    rdt("window", 1, `SP_XDATA, 16'h8100, 16'h0081, 6);
    wr(1, `SP_XDATA, 16'h8101, 16'h0000);
    rdt("window_ro", 1, `SP_XDATA, 16'h8101, 16'h00DA, 0);
  endtask

  task automatic t_aes();
    wr(0, `SP_XDATA, 16'h0041, 16'h0034);
    wr(0, `SP_XDATA, 16'h0042, 16'h0056);
    rdt("aes_odd", 2, `SP_XDATA, 16'h0041, 16'h5634, 2);
    wr(2, `SP_XDATA, 16'h1050, 16'hBEEF);
    rdt("aes_lo", 0, `SP_XDATA, 16'h1050, 16'h00EF, 1);
    rdt("aes_hi", 1, `SP_XDATA, 16'h1051, 16'h00BE, 1);
  endtask

  task automatic t_sleep();
    slp <= 1'b1;
    ret <= 2'h1;
    @(negedge clk);
    chk("pwr_keep0", 16'h0001, {14'h0000, pw});
    @(posedge clk);
    rdt("kept", 0, `SP_XDATA, 16'h0FFF, 16'h0011, 0);
    rdt("off", 0, `SP_XDATA, 16'h1000, 16'h0000, 0);
    ret <= 2'h2;
    @(negedge clk);
    chk("pwr_keep1", 16'h0002, {14'h0000, pw});
    @(posedge clk);
    slp <= 1'b0;
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_rr();
    t_par();
    t_map();
    t_flash();
    t_aes();
    t_sleep();
    summarize();
  end

  // The whole run needs under a hundred cycles; this leaves ample margin.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
